// file: gel_consts.vh
// register map, field positions, reset values and mode codes of the event/lookup block
`ifndef GEL_CONSTS_VH
`define GEL_CONSTS_VH

`define GEL_ADDR_IRQ_SRC    8'h08
`define GEL_ADDR_EVENT      8'h09
`define GEL_ADDR_MODE       8'h10
`define GEL_ADDR_TABLE0     8'h11
`define GEL_ADDR_TABLE1     8'h12
`define GEL_ADDR_TABLE2     8'h13
`define GEL_ADDR_TABLE3     8'h14
`define GEL_ADDR_TABLE4     8'h15

`define GEL_RESET_BYTE      8'h00
`define GEL_MODE_WMASK      8'h33

`define GEL_MODE_HI_MSB     5
`define GEL_MODE_HI_LSB     4
`define GEL_MODE_LO_MSB     1
`define GEL_MODE_LO_LSB     0

`define GEL_LUT_OFF         2'h0
`define GEL_LUT_2TO1        2'h1
`define GEL_LUT_3TO1        2'h2
`define GEL_LUT_3TO2        2'h3

`define GEL_EDGE_NONE       2'h0
`define GEL_EDGE_RISE       2'h1
`define GEL_EDGE_FALL       2'h2
`define GEL_EDGE_BOTH       2'h3

`endif

// file: gel_lookup.v
// combinational truth-table decode for the upper and lower pin nibbles
`timescale 1ns/1ps
`default_nettype none
`include "gel_consts.vh"

module gel_lookup (
  // configuration
  input  wire [7:0] lookup_mode_select,
  input  wire [7:0] two_input_truth_table,
  input  wire [7:0] upper_three_input_table,
  input  wire [7:0] lower_three_input_table,
  input  wire [7:0] split_table_pin4,
  input  wire [7:0] split_table_pin3,
  // pin levels
  input  wire [7:0] pin_level,
  // lookup result
  output reg  [7:0] drive_en,
  output reg  [7:0] drive_val
);

  wire [1:0] upper_nibble_logic_mode;
  wire [1:0] lower_nibble_logic_mode;

  assign upper_nibble_logic_mode = lookup_mode_select[`GEL_MODE_HI_MSB:`GEL_MODE_HI_LSB];
  assign lower_nibble_logic_mode = lookup_mode_select[`GEL_MODE_LO_MSB:`GEL_MODE_LO_LSB];

  always @* begin
    drive_en  = 8'h00;
    drive_val = 8'h00;
    // upper nibble; the reserved code leaves the pins as plain gpio
    case (upper_nibble_logic_mode)
      `GEL_LUT_2TO1: begin
        drive_en[6]  = 1'b1;
        drive_val[6] = two_input_truth_table[{1'b1, pin_level[5:4]}];
      end
      `GEL_LUT_3TO1: begin
        drive_en[7]  = 1'b1;
        drive_val[7] = upper_three_input_table[pin_level[6:4]];
      end
      default: begin
        drive_en[7:4] = 4'h0;
      end
    endcase
    // lower nibble; 3-to-2 reaches across into pin 4
    case (lower_nibble_logic_mode)
      `GEL_LUT_2TO1: begin
        drive_en[2]  = 1'b1;
        drive_val[2] = two_input_truth_table[{1'b0, pin_level[1:0]}];
      end
      `GEL_LUT_3TO1: begin
        drive_en[3]  = 1'b1;
        drive_val[3] = lower_three_input_table[pin_level[2:0]];
      end
      `GEL_LUT_3TO2: begin
        drive_en[4]  = 1'b1;
        drive_en[3]  = 1'b1;
        drive_val[4] = split_table_pin4[pin_level[2:0]];
        drive_val[3] = split_table_pin3[pin_level[2:0]];
      end
      default: begin
        drive_en[3:0] = 4'h0;
      end
    endcase
  end

endmodule // gel_lookup

`default_nettype wire

// file: gel_event_lookup.v
// edge event flags, interrupt source flags and lookup-logic pin driving
// What this block does
// - a pin's event flag sets on an edge matching its edge selection.
// - writing one to an event flag bit clears it and its interrupt source.
// - changing a pin's edge selection clears its event and interrupt flags.
// - upper mode 00 leaves pins 7..5 as gpio, and pin 4 unless lower mode is 11; 11 is reserved.
// - upper mode 01 drives pin 6 from table 0 indexed by pins 5:4.
// - upper mode 10 drives pin 7 from table 1 indexed by pins 6:4.
// - lower mode 00 leaves pins 3..0 as gpio.
// - lower mode 01 drives pin 2 from table 0 indexed by pins 1:0.
// - lower mode 10 drives pin 3 from table 2 indexed by pins 2:0.
// - lower mode 11 drives pins 4 and 3 from tables 3 and 4.
// - table 0 bits 7..4 give pin 6 for pins 5:4 = 11..00.
// - table 0 bits 3..0 give pin 2 for pins 1:0 = 11..00.
// - table 1 bit n drives pin 7 when pins 6:4 equal n.
// - table 2 bit n drives pin 3 when pins 2:0 equal n.
// - a table only affects pins while its mode selects it.
// - in 3-to-2 mode tables 3 and 4 drive pins 4 and 3.
// - edge select 00 none, 01 rising, 10 falling, 11 both.
// - interrupt output returns high once all source flags are clear.
`timescale 1ns/1ps
`default_nettype none
`include "gel_consts.vh"

module gel_event_lookup (
  // clock and reset
  input  wire       ref_clk,
  input  wire       resetn,
  // register port from the serial interface back end
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // neighbouring configuration
  input  wire [7:0] edge_select_upper,
  input  wire [7:0] edge_select_lower,
  input  wire [7:0] irq_mask,
  // pins
  input  wire [7:0] pin_level,
  output reg  [7:0] lookup_drive_en,
  output reg  [7:0] lookup_drive_val,
  // interrupt
  output reg  [7:0] irq_source_flags,
  output reg        irq_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  reg        rst_meta_n;
  reg        rst_n;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  function match_edge;
    input [1:0] sel;
    input       prev;
    input       now;
    begin
      case (sel)
        `GEL_EDGE_RISE: match_edge = ~prev & now;
        `GEL_EDGE_FALL: match_edge = prev & ~now;
        `GEL_EDGE_BOTH: match_edge = prev ^ now;
        default:        match_edge = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0]  pin_prev;
  reg  [15:0] sense_prev;
  wire [15:0] sense_now;
  reg  [7:0]  edge_hit;
  reg  [7:0]  sense_changed;
  integer     i;

  assign sense_now = {edge_select_upper, edge_select_lower};

  always @* begin
    edge_hit      = 8'h00;
    sense_changed = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      edge_hit[i]      = match_edge(sense_now[2*i +: 2], pin_prev[i], pin_level[i]);
      sense_changed[i] = |(sense_now[2*i +: 2] ^ sense_prev[2*i +: 2]);
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev   <= 8'h00;
      sense_prev <= 16'h0000;
    end else begin
      pin_prev   <= pin_level;
      sense_prev <= sense_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: a new edge in the clearing cycle wins over the clear

  reg  [7:0] edge_event_flags;
  wire       wr_event;
  wire       wr_irq_src;
  wire [7:0] flag_clear;
  wire [7:0] next_event;
  wire [7:0] next_irq_src;

  assign wr_event     = reg_wr && (reg_addr == `GEL_ADDR_EVENT);
  assign wr_irq_src   = reg_wr && (reg_addr == `GEL_ADDR_IRQ_SRC);
  assign flag_clear   = ((wr_event | wr_irq_src) ? reg_wdata : 8'h00)
                        | sense_changed;
  assign next_event   = (edge_event_flags & ~flag_clear) | edge_hit;
  assign next_irq_src = (irq_source_flags & ~flag_clear) | (edge_hit & ~irq_mask);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_event_flags <= `GEL_RESET_BYTE;
      irq_source_flags <= `GEL_RESET_BYTE;
      irq_out_n        <= 1'b1;
    end else begin
      edge_event_flags <= next_event;
      irq_source_flags <= next_irq_src;
      irq_out_n        <= ~|next_irq_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [7:0] lookup_mode_select;
  reg [7:0] two_input_truth_table;
  reg [7:0] upper_three_input_table;
  reg [7:0] lower_three_input_table;
  reg [7:0] split_table_pin4;
  reg [7:0] split_table_pin3;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lookup_mode_select      <= `GEL_RESET_BYTE;
      two_input_truth_table   <= `GEL_RESET_BYTE;
      upper_three_input_table <= `GEL_RESET_BYTE;
      lower_three_input_table <= `GEL_RESET_BYTE;
      split_table_pin4        <= `GEL_RESET_BYTE;
      split_table_pin3        <= `GEL_RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `GEL_ADDR_MODE) begin
        // reserved bits are not stored, so they always read back zero
        lookup_mode_select <= reg_wdata & `GEL_MODE_WMASK;
      end else if (reg_addr == `GEL_ADDR_TABLE0) begin
        two_input_truth_table <= reg_wdata;
      end else if (reg_addr == `GEL_ADDR_TABLE1) begin
        upper_three_input_table <= reg_wdata;
      end else if (reg_addr == `GEL_ADDR_TABLE2) begin
        lower_three_input_table <= reg_wdata;
      end else if (reg_addr == `GEL_ADDR_TABLE3) begin
        split_table_pin4 <= reg_wdata;
      end else if (reg_addr == `GEL_ADDR_TABLE4) begin
        split_table_pin3 <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back; unmapped addresses read zero

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `GEL_ADDR_IRQ_SRC) begin
        reg_rdata <= irq_source_flags;
      end else if (reg_addr == `GEL_ADDR_EVENT) begin
        reg_rdata <= edge_event_flags;
      end else if (reg_addr == `GEL_ADDR_MODE) begin
        reg_rdata <= lookup_mode_select;
      end else if (reg_addr == `GEL_ADDR_TABLE0) begin
        reg_rdata <= two_input_truth_table;
      end else if (reg_addr == `GEL_ADDR_TABLE1) begin
        reg_rdata <= upper_three_input_table;
      end else if (reg_addr == `GEL_ADDR_TABLE2) begin
        reg_rdata <= lower_three_input_table;
      end else if (reg_addr == `GEL_ADDR_TABLE3) begin
        reg_rdata <= split_table_pin4;
      end else if (reg_addr == `GEL_ADDR_TABLE4) begin
        reg_rdata <= split_table_pin3;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lookup logic; one register stage keeps the pin drive glitch free

  wire [7:0] lut_en;
  wire [7:0] lut_val;

  gel_lookup u_lookup (
    .lookup_mode_select      (lookup_mode_select),
    .two_input_truth_table   (two_input_truth_table),
    .upper_three_input_table (upper_three_input_table),
    .lower_three_input_table (lower_three_input_table),
    .split_table_pin4        (split_table_pin4),
    .split_table_pin3        (split_table_pin3),
    .pin_level               (pin_level),
    .drive_en                (lut_en),
    .drive_val               (lut_val)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lookup_drive_en  <= 8'h00;
      lookup_drive_val <= 8'h00;
    end else begin
      lookup_drive_en  <= lut_en;
      lookup_drive_val <= lut_val & lut_en;
    end
  end

endmodule // gel_event_lookup

`default_nettype wire

// file: gel_pin_model.sv
// pin-side model: board levels on free pins, block value on driven pins
`timescale 1ns/1ps
`default_nettype none
module gel_pin_model (
  // board side
  input  wire logic [7:0] ext_level,
  // block drive
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_val,
  // resolved pins
  output logic      [7:0] pin_level
);
  // resolved here so looked-up pins feed back like a real pad
  assign pin_level = (drive_en & drive_val) | (~drive_en & ext_level);
endmodule // gel_pin_model
`default_nettype wire

// file: gel_event_lookup_sva.sv
// assertions on flags, interrupt output and lookup drive
`timescale 1ns/1ps
`default_nettype none
module gel_event_lookup_sva (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // configuration, pins, interrupt
  input wire logic [7:0] edge_select_upper,
  input wire logic [7:0] edge_select_lower,
  input wire logic [7:0] irq_mask,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] lookup_drive_en,
  input wire logic [7:0] lookup_drive_val,
  input wire logic [7:0] irq_source_flags,
  input wire logic       irq_out_n
);
  logic [7:0] sh [0:5];
  logic [1:0] age;
  wire        live;
  wire  [1:0] lm;
  wire  [1:0] um;
  // shadow of mode and tables; wait out the internal reset stages
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      age <= 2'h0;
      for (int k = 0; k < 6; k++)
        sh[k] <= 8'h00;
    end else begin
      if (age != 2'h3)
        age <= age + 2'h1;
      if (reg_wr && reg_addr[7:4] == 4'h1 && reg_addr[3:0] < 4'h6)
        sh[reg_addr[2:0]] <= reg_wdata;
    end
  end
  assign live = (age == 2'h3);
  assign lm   = sh[0][1:0];
  assign um   = sh[0][5:4];
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!live);
  sequence s_w1c;
    reg_wr && reg_addr == 8'h09 && $stable(pin_level) && $stable(edge_select_lower);
  endsequence
  sequence s_rise;
    edge_select_lower[3:2] == 2'h1 && $rose(pin_level[1]) && !irq_mask[1];
  endsequence
  property p_w1c;
    s_w1c |=> (irq_source_flags & $past(reg_wdata)) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag kept after clear");
  property p_sel;
    edge_select_lower[5:4] != $past(edge_select_lower[5:4]) && $stable(pin_level[2])
      |=> !irq_source_flags[2];
  endproperty
  a_sel: assert property (p_sel) else $error("flag kept after select change");
  property p_irq;
    irq_out_n == (irq_source_flags == 8'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_rise;
    s_rise |=> irq_source_flags[1] && !irq_out_n;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_lo21;
    lm == 2'h1 |=> lookup_drive_en[2] && lookup_drive_val[2] == $past(sh[1][pin_level[1:0]]);
  endproperty
  a_lo21: assert property (p_lo21) else $error("pin 2 lookup wrong");
  property p_up31;
    um == 2'h2 |=> lookup_drive_en[7] && lookup_drive_val[7] == $past(sh[2][pin_level[6:4]]);
  endproperty
  a_up31: assert property (p_up31) else $error("pin 7 lookup wrong");
  property p_split;
    lm == 2'h3 |=> lookup_drive_val[4:3] ==
      {$past(sh[4][pin_level[2:0]]), $past(sh[5][pin_level[2:0]])};
  endproperty
  a_split: assert property (p_split) else $error("pins 4 3 lookup wrong");
  property p_off;
    lm == 2'h0 |=> lookup_drive_en[3:0] == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("lower pins driven");
endmodule // gel_event_lookup_sva
bind gel_event_lookup gel_event_lookup_sva chk_u (
  .ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .edge_select_upper, .edge_select_lower, .irq_mask, .pin_level,
  .lookup_drive_en, .lookup_drive_val, .irq_source_flags, .irq_out_n);
`default_nettype wire

// file: testbench.sv
// self-checking bench for the event flag and lookup block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       ref_clk, resetn, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, ext, edge_select_upper, edge_select_lower, irq_mask, i;
  wire  [7:0] reg_rdata, pin_level, lookup_drive_en, lookup_drive_val, irq_source_flags;
  wire        irq_out_n;
  logic [7:0] tt [0:5];
  logic [7:0] modes [0:4];
  logic [7:0] ens [0:4];
  int         err_total, tests_run;
  gel_event_lookup dut_u (
    .ref_clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .edge_select_upper, .edge_select_lower, .irq_mask, .pin_level,
    .lookup_drive_en, .lookup_drive_val, .irq_source_flags, .irq_out_n);
  gel_pin_model pins_u (
    .ext_level(ext), .drive_en(lookup_drive_en), .drive_val(lookup_drive_val), .pin_level);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk("reg_rdata", e, reg_rdata);
  endtask
  function automatic logic [7:0] exp_pins(input logic [7:0] md, input logic [7:0] k);
    case (md)
      8'h11: exp_pins = {1'b0, tt[1][k[1:0] + 4], 3'h0, tt[1][k[1:0]], 2'h0};
      8'h22: exp_pins = {tt[2][k[2:0]], 3'h0, tt[3][k[2:0]], 3'h0};
      8'h03: exp_pins = {3'h0, tt[4][k[2:0]], tt[5][k[2:0]], 3'h0};
      default: exp_pins = 8'h00;
    endcase
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd} = 3'b000;
    {reg_addr, reg_wdata, ext, irq_mask} = 32'h0;
    {edge_select_upper, edge_select_lower} = 16'h0;
    err_total = 0;
    tests_run = 0;
    tt = '{8'h00, 8'h5a, 8'h96, 8'h3c, 8'hc5, 8'h71};
    modes = '{8'h11, 8'h22, 8'h03, 8'h30, 8'h00};
    ens = '{8'h44, 8'h88, 8'h18, 8'h00, 8'h00};
    tick(6);
    resetn = 1'b1;
    tick(3);
    // unmapped offsets in this span must read zero too
    for (i = 8'h08; i < 8'h16; i++) rd(i, 8'h00);
    chk("lookup_drive_en", 8'h00, lookup_drive_en);
    for (i = 8'h01; i < 8'h06; i++) wr(8'h10 + i, tt[i]);
    for (int m = 0; m < 5; m++) begin
      wr(8'h10, modes[m]);
      rd(8'h10, modes[m]);
      for (i = 8'h00; i < 8'h08; i++) begin
        ext = {1'b0, i[2:0], 1'b0, i[2:0]};
        tick(2);
        chk("lookup_pins", exp_pins(modes[m], i), pin_level & lookup_drive_en);
        chk("lookup_drive_en", ens[m], lookup_drive_en);
      end
    end
    ext = 8'h00;
    tick(2);
    edge_select_lower = 8'he4;
    tick(2);
    ext = 8'h0f;
    tick(2);
    rd(8'h09, 8'h0a);
    chk("irq_out_n", 8'h00, {7'h0, irq_out_n});
    wr(8'h09, 8'h02);
    rd(8'h08, 8'h08);
    ext = 8'h00;
    tick(2);
    rd(8'h09, 8'h0c);
    edge_select_lower = 8'hd4;
    tick(2);
    rd(8'h09, 8'h08);
    wr(8'h09, 8'hff);
    rd(8'h08, 8'h00);
    chk("irq_out_n", 8'h01, {7'h0, irq_out_n});
    // masked pin: event flag sets, interrupt source and output stay quiet
    irq_mask = 8'h80;
    edge_select_upper = 8'h40;
    tick(2);
    ext = 8'h80;
    tick(2);
    rd(8'h09, 8'h80);
    rd(8'h08, 8'h00);
    chk("irq_out_n", 8'h01, {7'h0, irq_out_n});
    // a one written at the interrupt source offset clears the event flag too
    wr(8'h08, 8'h80);
    rd(8'h09, 8'h00);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
